// *** abts_consts.svh ***
/*
  Constants for the abort-sequence handler: parameter-field layout, reason
  codes, frame-control bit positions and accept-payload encodings.
  Assumes inclusion by bare name from the package and both ends.
*/
`ifndef ABTS_CONSTS_SVH
`define ABTS_CONSTS_SVH
`define PARAM_TYPE_BIT      0
`define PARAM_REASON_LSB    8
`define PARAM_REASON_MSB    15
`define FCTL_SEQ_INIT_BIT   16
`define FCTL_END_SEQ_BIT    19
`define ACK_ABORT_MSB       5
`define ACK_ABORT_LSB       4
`define ACK_ABORT_REQ       2'b01
`define REASON_NONE         8'h00
`define REASON_LAST_STD     8'h08
`define REASON_ULP_LO       8'h81
`define REASON_ULP_HI       8'h9f
`define REASON_SEQ_TIMEOUT  8'h05
`define SEQID_VALID         8'h80
`define SEQID_INVALID       8'h00
`define SEQCNT_ZERO         16'h0000
`endif

// *** abts_pkg.sv ***
/*
  Types shared by both ends of the abort-sequence handler.
  Assumes abts_consts.svh is on the include path.
*/
package abts_pkg;
`include "abts_consts.svh"
  typedef enum logic [1:0] {
    CLS_REASON_STD,
    CLS_REASON_ULP,
    CLS_REASON_RSVD
  } reason_class_t;

  // Reason code classification used by the initiator
  function automatic reason_class_t classify_reason(input logic [7:0] code);
    if (code <= `REASON_LAST_STD) begin
      return CLS_REASON_STD;
    end else if (code >= `REASON_ULP_LO && code <= `REASON_ULP_HI) begin
      return CLS_REASON_ULP;
    end
    return CLS_REASON_RSVD;
  endfunction
endpackage

// *** abts_link_if.sv ***
/*
  Link carrier between abort initiator and abort recipient.
  Assumes both ends share clk_sys; single-cycle valid strobes.
*/
`timescale 1ns/10ps
interface abts_link_if;
  // Abort frame, initiator to recipient
  logic        abts_valid;
  logic [31:0] abts_param;
  logic [31:0] abts_fctl;
  logic [7:0]  abts_seq_id;
  logic [15:0] abts_seq_cnt;
  logic [15:0] abts_ox_id;
  logic [15:0] abts_rx_id;
  logic [3:0]  abts_class;
  // Accept reply, recipient to initiator
  logic        acc_valid;
  logic [31:0] acc_fctl;
  logic [7:0]  acc_seqid_vld;
  logic [7:0]  acc_seq_id;
  logic [15:0] acc_low_cnt;
  logic [15:0] acc_high_cnt;
  logic [15:0] acc_ox_id;
  logic [15:0] acc_rx_id;
  // Acknowledge abort condition, recipient to initiator
  logic        ack_valid;
  logic [31:0] ack_fctl;

  modport initiator (
    output abts_valid, abts_param, abts_fctl, abts_seq_id, abts_seq_cnt,
           abts_ox_id, abts_rx_id, abts_class,
    input  acc_valid, acc_fctl, acc_seqid_vld, acc_seq_id, acc_low_cnt,
           acc_high_cnt, acc_ox_id, acc_rx_id, ack_valid, ack_fctl
  );
  modport recipient (
    input  abts_valid, abts_param, abts_fctl, abts_seq_id, abts_seq_cnt,
           abts_ox_id, abts_rx_id, abts_class,
    output acc_valid, acc_fctl, acc_seqid_vld, acc_seq_id, acc_low_cnt,
           acc_high_cnt, acc_ox_id, acc_rx_id, ack_valid, ack_fctl
  );
endinterface

// *** abts_recipient.sv ***
/*
  Abort recipient end: requests aborts via acknowledge, answers each abort
  frame with one accept, then filters data frames in the recovery range.
  Assumes synchronous user inputs on clk_sys and the link interface.
*/
`timescale 1ns/10ps
`include "abts_consts.svh"
module abts_recipient
  import abts_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Link
  abts_link_if.recipient   link,
  // Sequence state from the recipient's tracker
  input  wire logic        last_dlv_known,
  input  wire logic [7:0]  last_dlv_seq_id,
  input  wire logic [15:0] last_dlv_cnt,
  input  wire logic        pass_initiative,
  input  wire logic        req_abort,
  // Incoming data frames to filter
  input  wire logic        data_valid,
  input  wire logic [15:0] data_seq_cnt,
  output logic             data_keep,
  // Status
  output logic             rq_active,
  output logic [15:0]      rq_low,
  output logic [15:0]      rq_high,
  output logic             abort_exchange,
  output logic [7:0]       abort_reason
);
  typedef struct packed {
    logic        acc_valid;
    logic [31:0] acc_fctl;
    logic [7:0]  acc_seqid_vld;
    logic [7:0]  acc_seq_id;
    logic [15:0] acc_low;
    logic [15:0] acc_high;
    logic [15:0] acc_ox;
    logic [15:0] acc_rx;
    logic        ack_valid;
    logic [31:0] ack_fctl;
    logic        rq_active;
    logic [15:0] rq_low;
    logic [15:0] rq_high;
    logic        xchg;
    logic [7:0]  reason;
  } rcp_state_t;

  rcp_state_t st_reg;
  rcp_state_t st_next;

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next           = st_reg;
    st_next.acc_valid = 1'b0;
    st_next.ack_valid = 1'b0;
    // Abort condition 01b in an acknowledge
    if (req_abort) begin
      st_next.ack_valid = 1'b1;
      st_next.ack_fctl  = '0;
      st_next.ack_fctl[`ACK_ABORT_MSB:`ACK_ABORT_LSB] = `ACK_ABORT_REQ;
    end
    // Accepted whatever initiative state; answered next cycle, no timeout wait
    if (link.abts_valid) begin
      st_next.acc_valid = 1'b1;
      st_next.acc_ox    = link.abts_ox_id;
      st_next.acc_rx    = link.abts_rx_id;
      st_next.xchg      = ~link.abts_param[`PARAM_TYPE_BIT];
      st_next.reason    = link.abts_param[`PARAM_REASON_MSB:`PARAM_REASON_LSB];
      st_next.acc_fctl  = '0;
      st_next.acc_fctl[`FCTL_SEQ_INIT_BIT] = pass_initiative;
      st_next.acc_high  = link.abts_seq_cnt;
      if (last_dlv_known) begin
        st_next.acc_seqid_vld = `SEQID_VALID;
        st_next.acc_seq_id    = last_dlv_seq_id;
        st_next.acc_low       = last_dlv_cnt;
      end else begin
        st_next.acc_seqid_vld = `SEQID_INVALID;
        st_next.acc_seq_id    = 8'h00;
        st_next.acc_low       = `SEQCNT_ZERO;
      end
      // Range in error; empty when low equals high
      st_next.rq_low    = st_next.acc_low;
      st_next.rq_high   = link.abts_seq_cnt;
      st_next.rq_active = (st_next.acc_low != link.abts_seq_cnt);
    end
  end

  // Single register stage; clock enable freezes all state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs; range goes live in the same cycle the accept leaves
  assign link.acc_valid     = st_reg.acc_valid;
  assign link.acc_fctl      = st_reg.acc_fctl;
  assign link.acc_seqid_vld = st_reg.acc_seqid_vld;
  assign link.acc_seq_id    = st_reg.acc_seq_id;
  assign link.acc_low_cnt   = st_reg.acc_low;
  assign link.acc_high_cnt  = st_reg.acc_high;
  assign link.acc_ox_id     = st_reg.acc_ox;
  assign link.acc_rx_id     = st_reg.acc_rx;
  assign link.ack_valid     = st_reg.ack_valid;
  assign link.ack_fctl      = st_reg.ack_fctl;
  assign rq_active          = st_reg.rq_active;
  assign rq_low             = st_reg.rq_low;
  assign rq_high            = st_reg.rq_high;
  assign abort_exchange     = st_reg.xchg;
  assign abort_reason       = st_reg.reason;

  // Discard frames in the range; low bound is the last good frame, exclusive
  assign data_keep = data_valid & ~(st_reg.rq_active &&
                     data_seq_cnt > st_reg.rq_low &&
                     data_seq_cnt <= st_reg.rq_high);
endmodule

// *** abts_initiator.sv ***
/*
  Abort initiator end: builds the abort frame, freezes upward delivery
  until the accept is processed and any recovery is done, and judges whether recovery is needed.
  Assumes synchronous user inputs on clk_sys and the link interface.
*/
`timescale 1ns/10ps
`include "abts_consts.svh"
module abts_initiator
  import abts_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // Link
  abts_link_if.initiator   link,
  // Trigger and frame context
  input  wire logic        seq_timeout,
  input  wire logic        prj_abort,
  input  wire logic        abort_seqs,
  input  wire logic [7:0]  reason,
  input  wire logic [31:0] last_fctl,
  input  wire logic [7:0]  last_seq_id,
  input  wire logic [15:0] last_seq_cnt,
  input  wire logic [15:0] ox_id,
  input  wire logic [15:0] rx_id,
  input  wire logic [3:0]  last_class,
  input  wire logic        recovery_done,
  // Status
  output logic             busy,
  output logic             deliver_en,
  output logic             timers_restart,
  output logic             recovery_needed,
  output logic             got_initiative
);
  typedef enum logic [1:0] {IDLE, WAIT_ACC, RECOVER} ini_phase_t;
  typedef struct packed {
    ini_phase_t  phase;
    logic        tx;
    logic [31:0] param;
    logic [31:0] fctl;
    logic [7:0]  seq_id;
    logic [15:0] seq_cnt;
    logic [15:0] ox;
    logic [15:0] rx;
    logic [3:0]  cls;
    logic        restart;
    logic        rec_need;
    logic        init;
  } ini_state_t;

  ini_state_t st_reg;
  ini_state_t st_next;
  logic       trigger;
  logic       ack_req;
  logic [7:0] rsn;

  //////////////////////////////////////////////////////////////////////////
  // Triggers; credit, initiative and open-sequence state are not consulted
  assign ack_req = link.ack_valid &&
                   link.ack_fctl[`ACK_ABORT_MSB:`ACK_ABORT_LSB] == `ACK_ABORT_REQ;
  assign trigger = seq_timeout | prj_abort | ack_req;
  // Timeout names its own reason; reserved codes fall back to no explanation
  assign rsn = seq_timeout ? `REASON_SEQ_TIMEOUT :
               ((classify_reason(reason) == CLS_REASON_RSVD) ? `REASON_NONE : reason);

  // Next state
  always_comb begin
    st_next         = st_reg;
    st_next.tx      = 1'b0;
    st_next.restart = 1'b0;
    unique case (st_reg.phase)
      IDLE: begin
        if (trigger) begin
          st_next.phase   = WAIT_ACC;
          st_next.tx      = 1'b1;
          st_next.restart = 1'b1;
          st_next.param   = '0;
          st_next.param[`PARAM_TYPE_BIT] = abort_seqs;
          st_next.param[`PARAM_REASON_MSB:`PARAM_REASON_LSB] = rsn;
          st_next.fctl    = last_fctl;
          st_next.fctl[`FCTL_SEQ_INIT_BIT] = 1'b1;
          st_next.fctl[`FCTL_END_SEQ_BIT]  = 1'b1;
          st_next.seq_id  = last_seq_id;
          st_next.seq_cnt = 16'(last_seq_cnt + 16'h0001);
          st_next.ox      = ox_id;
          st_next.rx      = rx_id;
          st_next.cls     = last_class;
        end
      end
      WAIT_ACC: begin
        if (link.acc_valid && link.acc_ox_id == st_reg.ox && link.acc_rx_id == st_reg.rx) begin
          st_next.init     = link.acc_fctl[`FCTL_SEQ_INIT_BIT];
          st_next.rec_need = !(link.acc_low_cnt == link.acc_high_cnt &&
                               link.acc_seqid_vld == `SEQID_VALID &&
                               link.acc_seq_id == st_reg.seq_id);
          st_next.phase    = st_next.rec_need ? RECOVER : IDLE;
        end
      end
      RECOVER: begin
        if (recovery_done) begin
          st_next.phase = IDLE;
        end
      end
      default: st_next.phase = IDLE;
    endcase
  end

  // Single register stage; clock enable freezes all state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.abts_valid   = st_reg.tx;
  assign link.abts_param   = st_reg.param;
  assign link.abts_fctl    = st_reg.fctl;
  assign link.abts_seq_id  = st_reg.seq_id;
  assign link.abts_seq_cnt = st_reg.seq_cnt;
  assign link.abts_ox_id   = st_reg.ox;
  assign link.abts_rx_id   = st_reg.rx;
  assign link.abts_class   = st_reg.cls;
  assign busy              = st_reg.phase != IDLE;
  assign deliver_en        = st_reg.phase == IDLE;
  assign timers_restart    = st_reg.restart;
  assign recovery_needed   = st_reg.rec_need;
  assign got_initiative    = st_reg.init;
endmodule

// *** abts_monitor.sv ***
/*
  Link checks between the abort initiator and the abort recipient.
  Assumes one clock domain; inputs come straight from the link interface.
*/
`timescale 1ns/10ps
module abts_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Abort frame
  input wire logic        abts_valid,
  input wire logic [31:0] abts_param,
  input wire logic [31:0] abts_fctl,
  input wire logic [15:0] abts_seq_cnt,
  // Accept and acknowledge
  input wire logic        acc_valid,
  input wire logic [7:0]  acc_seqid_vld,
  input wire logic [15:0] acc_low_cnt,
  input wire logic [15:0] acc_high_cnt,
  input wire logic        ack_valid,
  input wire logic [31:0] ack_fctl
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Abort out, then its accept carrying the abort count
  sequence abort_sent;
    abts_valid;
  endsequence
  sequence accept_back;
    acc_valid && acc_high_cnt == $past(abts_seq_cnt);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  acc_reply_a: assert property (abort_sent |=> accept_back)
    else $error("abort not answered by matching accept");
  acc_cause_a: assert property (acc_valid |-> $past(abts_valid))
    else $error("accept without abort");
  abts_pulse_a: assert property (abts_valid |=> !abts_valid)
    else $error("abort longer than one cycle");
  fctl_bits_a: assert property (abts_valid |-> abts_fctl[16] && abts_fctl[19])
    else $error("abort frame control bits missing");
  param_rsvd_a: assert property (abts_valid |-> abts_param[31:16] == 16'h0000 && abts_param[7:1] == 7'h00)
    else $error("reserved parameter bits set");
  reason_code_a: assert property (abts_valid |-> abts_param[15:8] <= 8'h08 ||
    (abts_param[15:8] >= 8'h81 && abts_param[15:8] <= 8'h9f))
    else $error("reserved reason code sent");
  seqid_code_a: assert property (acc_valid |-> acc_seqid_vld == 8'h80 ||
    (acc_seqid_vld == 8'h00 && acc_low_cnt == 16'h0000))
    else $error("bad seq id validity");
  ack_cond_a: assert property (ack_valid |-> ack_fctl[5:4] == 2'b01)
    else $error("ack without abort condition");
endmodule

// *** tb.sv ***
/*
  Self-checking bench: both ends joined by the link, checker beside it.
  Assumes nothing beyond the two ends; clk_en is dropped in one scenario.
*/
`timescale 1ns/10ps
module tb;
  import abts_pkg::*;
  logic        clk_sys = 0, resetn = 0, clk_en = 1, seq_timeout = 0, prj_abort = 0, abort_seqs = 0;
  logic        recovery_done = 0, req_abort = 0, last_dlv_known = 0, pass_initiative = 0, data_valid = 0;
  logic [7:0]  reason = 0, last_seq_id = 8'h11, last_dlv_seq_id = 0, abort_reason;
  logic [31:0] last_fctl = 32'h0020_0000;
  logic [15:0] last_seq_cnt = 16'h0040, ox_id = 16'h1234, rx_id = 16'h5678, last_dlv_cnt = 0, data_seq_cnt = 0;
  logic [15:0] rq_low, rq_high;
  logic [3:0]  last_class = 4'h3;
  logic        busy, deliver_en, timers_restart, recovery_needed, got_initiative, data_keep, rq_active;
  logic        abort_exchange;
  int          n_mismatch = 0, n_tests = 0;
  abts_link_if link();
  abts_initiator abts_initiator_i(.clk_sys, .resetn, .clk_en, .link(link), .seq_timeout, .prj_abort,
    .abort_seqs, .reason, .last_fctl, .last_seq_id, .last_seq_cnt, .ox_id, .rx_id, .last_class,
    .recovery_done, .busy, .deliver_en, .timers_restart, .recovery_needed, .got_initiative);
  abts_recipient abts_recipient_i(.clk_sys, .resetn, .clk_en, .link(link), .last_dlv_known,
    .last_dlv_seq_id, .last_dlv_cnt, .pass_initiative, .req_abort, .data_valid, .data_seq_cnt,
    .data_keep, .rq_active, .rq_low, .rq_high, .abort_exchange, .abort_reason);
  abts_monitor abts_monitor_i(.clk_sys, .resetn, .abts_valid(link.abts_valid), .abts_param(link.abts_param),
    .abts_fctl(link.abts_fctl), .abts_seq_cnt(link.abts_seq_cnt), .acc_valid(link.acc_valid),
    .acc_seqid_vld(link.acc_seqid_vld), .acc_low_cnt(link.acc_low_cnt), .acc_high_cnt(link.acc_high_cnt),
    .ack_valid(link.ack_valid), .ack_fctl(link.ack_fctl));
  // 40 MHz system clock
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Abort frame fields, looked at in its single valid cycle
  task automatic chk_abts(input logic [7:0] exp_reason);
    chk("abts_valid", 1, link.abts_valid);
    chk("abts_param", {16'h0000, exp_reason, 7'h00, abort_seqs}, link.abts_param);
    chk("abts_fctl", last_fctl | 32'h0009_0000, link.abts_fctl);
    chk("abts_seq_id", last_seq_id, link.abts_seq_id);
    chk("abts_seq_cnt", 16'(last_seq_cnt + 16'h0001), link.abts_seq_cnt);
    chk("abts_class", last_class, link.abts_class);
    chk("abts_ids", {ox_id, rx_id}, {link.abts_ox_id, link.abts_rx_id});
    chk("timers_restart", 1, timers_restart);
    chk("deliver_en", 0, deliver_en);
    chk("busy", 1, busy);
  endtask
  // Trigger by timeout or reject, wait for the frame under a bound
  task automatic send_abort(input logic by_timeout, input logic [7:0] exp_reason);
    @(posedge clk_sys);
    if (by_timeout) seq_timeout <= 1'b1;
    else prj_abort <= 1'b1;
    for (int i = 0; i < 8 && link.abts_valid !== 1'b1; i++) begin
      @(posedge clk_sys);
      seq_timeout <= 1'b0;
      prj_abort <= 1'b0;
      #1;
    end
    chk_abts(exp_reason);
  endtask
  // Accept one cycle on, then the initiator's verdict
  task automatic chk_accept(input logic [15:0] lo, input logic [7:0] vld, input logic [7:0] id, input logic rec);
    logic [15:0] hi;
    hi = 16'(last_seq_cnt + 16'h0001);
    @(posedge clk_sys);
    #1;
    chk("acc_valid", 1, link.acc_valid);
    chk("acc_cnts", {lo, hi}, {link.acc_low_cnt, link.acc_high_cnt});
    chk("acc_seqid", {vld, id}, {link.acc_seqid_vld, link.acc_seq_id});
    chk("acc_init", pass_initiative, link.acc_fctl[16]);
    chk("rq_active", lo != hi, rq_active);
    chk("timers_once", 0, timers_restart);
    @(posedge clk_sys);
    #1;
    chk("acc_once", 0, link.acc_valid);
    chk("recovery_needed", rec, recovery_needed);
    chk("deliver_after", !rec, deliver_en);
    chk("busy_after", rec, busy);
    chk("got_initiative", pass_initiative, got_initiative);
  endtask
  task automatic end_recovery;
    @(posedge clk_sys);
    recovery_done <= 1'b1;
    @(posedge clk_sys);
    recovery_done <= 1'b0;
    #1;
    chk("deliver_resume", 1, deliver_en);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Timeout forces its own reason; matching accept needs no recovery
  task automatic test_clean;
    abort_seqs <= 1'b1;
    reason <= 8'h03;
    last_dlv_known <= 1'b1;
    last_dlv_seq_id <= last_seq_id;
    last_dlv_cnt <= 16'h0041;
    pass_initiative <= 1'b1;
    send_abort(1'b1, 8'h05);
    chk_accept(16'h0041, 8'h80, last_seq_id, 1'b0);
    chk("abort_exchange", 0, abort_exchange);
    chk("abort_reason", 8'h05, abort_reason);
    $display("test clean done");
  endtask
  // Every reason class; unknown last sequence means recovery
  task automatic test_reasons;
    logic [7:0] codes [8] = '{8'h00, 8'h08, 8'h09, 8'h80, 8'h81, 8'h9f, 8'ha0, 8'hff};
    logic [7:0] c;
    foreach (codes[i]) begin
      c = codes[i];
      abort_seqs <= 1'b0;
      reason <= c;
      last_dlv_known <= 1'b0;
      pass_initiative <= 1'b0;
      last_seq_cnt <= 16'h0100 + 16'(i);
      if (!(c <= 8'h08 || (c >= 8'h81 && c <= 8'h9f))) c = 8'h00;
      send_abort(1'b0, c);
      chk_accept(16'h0000, 8'h00, 8'h00, 1'b1);
      chk("abort_exchange", 1, abort_exchange);
      chk("abort_reason", c, abort_reason);
      end_recovery();
    end
    $display("test reasons done");
  endtask
  // Known last sequence behind the abort; frames in range dropped
  task automatic test_filter;
    logic [15:0] cnts [4] = '{16'h0010, 16'h0011, 16'h0014, 16'h0015};
    abort_seqs <= 1'b1;
    reason <= 8'h07;
    last_seq_cnt <= 16'h0013;
    last_dlv_known <= 1'b1;
    last_dlv_seq_id <= 8'h0f;
    last_dlv_cnt <= 16'h0010;
    send_abort(1'b0, 8'h07);
    chk_accept(16'h0010, 8'h80, 8'h0f, 1'b1);
    chk("rq_range", {16'h0010, 16'h0014}, {rq_low, rq_high});
    foreach (cnts[i]) begin
      @(posedge clk_sys);
      data_valid <= 1'b1;
      data_seq_cnt <= cnts[i];
      #1;
      chk("data_keep", i == 0 || i == 3, data_keep);
    end
    @(posedge clk_sys);
    data_valid <= 1'b0;
    end_recovery();
    $display("test filter done");
  endtask
  // Recipient asks for the abort through the acknowledge condition
  task automatic test_ack;
    reason <= 8'h04;
    last_seq_cnt <= 16'h0200;
    last_dlv_known <= 1'b1;
    last_dlv_seq_id <= last_seq_id;
    last_dlv_cnt <= 16'h0201;
    pass_initiative <= 1'b0;
    @(posedge clk_sys);
    req_abort <= 1'b1;
    @(posedge clk_sys);
    req_abort <= 1'b0;
    #1;
    chk("ack", 3'b101, {link.ack_valid, link.ack_fctl[5:4]});
    @(posedge clk_sys);
    #1;
    chk_abts(8'h04);
    chk_accept(16'h0201, 8'h80, last_seq_id, 1'b0);
    $display("test ack done");
  endtask
  // Equal counts under another sequence id still need recovery; freeze, then reset mid-run
  task automatic test_freeze;
    last_seq_cnt <= 16'h0300;
    last_dlv_known <= 1'b1;
    last_dlv_seq_id <= 8'h22;
    last_dlv_cnt <= 16'h0301;
    send_abort(1'b0, 8'h04);
    chk_accept(16'h0301, 8'h80, 8'h22, 1'b1);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    recovery_done <= 1'b1;
    @(posedge clk_sys);
    recovery_done <= 1'b0;
    @(posedge clk_sys);
    clk_en <= 1'b1;
    #1;
    chk("frozen_deliver", 0, deliver_en);
    chk("frozen_need", 1, recovery_needed);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("reset_state", 4'b1000, {deliver_en, busy, recovery_needed, rq_active});
    resetn <= 1'b1;
    @(posedge clk_sys);
    $display("test freeze done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    test_clean();
    test_reasons();
    test_filter();
    test_ack();
    test_freeze();
    final_report();
  end
  // Whole run is under a hundred cycles; this cuts a hang short
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end
endmodule
